// ---- hw/agw_pkg.sv ----
// Summary of operation
// (RULE_01) Readback shows all eight pin levels in any direction; no reset.
// (RULE_02) Readback bit asserted for high pin, or low pin if inverted.
// (RULE_03) Set mask bit enables that pin's interrupt; mask resets to zero.
// (RULE_04) Status bit sets on rising edge, or falling edge if inverted.
// (RULE_05) Status reads latched flags; a one clears a flag, zero leaves it.
// (RULE_06) Function bits 7-4 make pins 8,7 captures and 6,5 compares.
// (RULE_07) Bit 3 makes pin 4 the watchdog trigger, low-true unless inverted.
// (RULE_08) Bit 2 passes pin 3 to processor wake, low-true unless inverted.
// (RULE_09) Bit 1 passes pin 2 to wireless disable, low-true unless inverted.
// (RULE_10) Bit 0 passes pin 1 to module sleep, low-true unless inverted.
// (RULE_11) Mode clears on platform reset only if keep-alive is zero.
// (RULE_12) Mask clears on platform reset; software reprograms after sleep.
// (RULE_13) Pin gate bit 7 and three-bit select map onto serial IRQ lines.
// (RULE_14) Watchdog control: gate bit 7, line select 6-4, both reset zero.
// (RULE_15) Fired watchdog resets board only if reset-enable bit is one.
// (RULE_16) Watchdog runs only while enabled; software loads timeout first.
// (RULE_17) Fired flag sets on firing; timeout write, disable, reset clear it.
// (RULE_18) Enabled watchdog fires while timeout is zero; it resets to zero.
// (RULE_19) Timeout counts down once per free-running one-second tick.
// (RULE_20) Every timeout write reloads the countdown.
// (RULE_21) Software writes timeouts 2 to 255, one above the wanted time.
// (RULE_22) Polarity inverts both logical level and interrupt edge.
// (RULE_23) Firing sets the flag and, if enabled, interrupt and board reset.
// (RULE_24) Pin request is OR of masked flags, driven while group gate is one.
// (RULE_25) Watchdog request follows fired flag on selected line while gated.
package agw_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES   = TICK_PERIOD_S * CLK_HZ;

  // ==========================================================================
  // Sizes
  localparam int unsigned NUM_PINS  = 8;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned IRQ_LINES = 16;

  // ==========================================================================
  // Register offsets (byte registers in the I/O window)
  localparam logic [3:0] OFS_PIN_INPUT_READBACK    = 4'h0;
  localparam logic [3:0] OFS_PIN_INTERRUPT_MASK    = 4'h1;
  localparam logic [3:0] OFS_PIN_INTERRUPT_STATUS  = 4'h2;
  localparam logic [3:0] OFS_PIN_FUNCTION_SELECT   = 4'h3;
  localparam logic [3:0] OFS_PIN_INTERRUPT_ROUTING = 4'h4;
  localparam logic [3:0] OFS_WATCHDOG_CONTROL      = 4'h5;
  localparam logic [3:0] OFS_WATCHDOG_TIMEOUT      = 4'h6;
  localparam logic [3:0] OFS_PIN_POLARITY_INVERT   = 4'h7;

  // ==========================================================================
  // Field positions
  localparam int unsigned GATE_BIT      = 7;
  localparam int unsigned SEL_LSB       = 4;
  localparam int unsigned RESET_EN_BIT  = 2;
  localparam int unsigned RUN_BIT       = 1;
  localparam int unsigned FIRED_BIT     = 0;
  localparam int unsigned FN_CAPTURE3   = 7;
  localparam int unsigned FN_CAPTURE4   = 6;
  localparam int unsigned FN_COMPARE3   = 5;
  localparam int unsigned FN_COMPARE4   = 4;
  localparam int unsigned FN_WDG_TRIG   = 3;
  localparam int unsigned FN_WAKE       = 2;
  localparam int unsigned FN_WDISABLE   = 1;
  localparam int unsigned FN_SLEEP      = 0;
  localparam logic [7:0]  FN_DRIVE_MASK = 8'h38;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_SEL  = 3'h0;
  localparam logic [7:0] RST_OE_B = 8'hff;
  localparam logic [4:0] RST_ALT  = 5'h07;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic             rd;
    logic             wr;
    logic [3:0]       addr;
    logic [7:0]       wdata;
  } agw_reg_req_t;

  typedef struct packed {
    logic capture_input_three;
    logic capture_input_four;
    logic proc_wake_b;
    logic wireless_disable_b;
    logic sleep_b;
  } agw_alt_t;

  // Serial IRQ line number for a three-bit select
  function automatic logic [3:0] agw_irq_line(input logic [2:0] sel);
    logic [3:0] line;
    line = 4'h3;
    unique case (sel)
      3'h0: line = 4'h3;
      3'h1: line = 4'h4;
      3'h2: line = 4'h5;
      3'h3: line = 4'ha;
      3'h4: line = 4'h6;
      3'h5: line = 4'h7;
      3'h6: line = 4'h9;
      3'h7: line = 4'hb;
    endcase
    return line;
  endfunction : agw_irq_line

endpackage : agw_pkg

// ---- hw/agw_pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module agw_pin_sync #(
  parameter int unsigned WIDTH = 9
) (
  // Clock, reset and enable
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  // Asynchronous inputs and their filtered levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level
);

  // ==========================================================================
  // Three-stage synchroniser; a change counts once stages two and three agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        s1       <= 1'b0;
        s2       <= 1'b0;
        s3       <= 1'b0;
        level[i] <= 1'b0;
      end else if (ce) begin
        s1 <= async_in[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          level[i] <= s3;
        end
      end
    end
  end

endmodule : agw_pin_sync
`default_nettype wire

// ---- hw/agw_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module agw_top #(
  parameter int unsigned TICK_CYCLES_P = agw_pkg::TICK_CYCLES
) (
  // Clock, reset and enable
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire logic                 ce,
  // Platform reset (asynchronous pin) and keep-alive setting
  input  wire logic                 plt_rst_b,
  input  wire logic                 aux_power_keep_alive,
  // Byte register port
  input  wire agw_pkg::agw_reg_req_t reg_req,
  output logic [7:0]                reg_rdata,
  // Auxiliary pins
  input  wire logic [7:0]           pin_in,
  output logic [7:0]                pin_out,
  output logic [7:0]                pin_oe_b,
  // Plain GPIO drive from the direction and output registers
  input  wire logic [7:0]           gpio_drive_en,
  input  wire logic [7:0]           gpio_drive_val,
  // Timer compare outputs
  input  wire logic                 compare_output_three,
  input  wire logic                 compare_output_four,
  // Alternate-function results
  output var agw_pkg::agw_alt_t     alt_out,
  output logic                      board_reset_req,
  // Serial IRQ requests and slot activity
  output logic [15:0]               irq_req,
  output logic [15:0]               irq_slot_en
);
  import agw_pkg::*;

  localparam int unsigned TW = $clog2(TICK_CYCLES_P + 1);

  // ==========================================================================
  // Pin synchronisers
  logic [8:0] sync_level;

  agw_pin_sync #(
    .WIDTH(NUM_PINS + 1)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .async_in({plt_rst_b, pin_in}),
    .level   (sync_level)
  );

  wire [7:0] pin_levels = sync_level[7:0];
  wire       plt_reset  = ~sync_level[8];
  wire       mode_reset = plt_reset & ~aux_power_keep_alive;  // [RULE_11]

  // ==========================================================================
  // Registers
  logic [7:0]    pin_polarity_invert;
  logic [7:0]    pin_interrupt_mask;
  logic [7:0]    pin_edge_flags;
  logic [7:0]    pin_function_select;
  logic          pin_irq_gate;
  logic [2:0]    pin_line_select;
  logic          wdg_irq_gate;
  logic [2:0]    wdg_line_select;
  logic          wdg_reset_en;
  logic          watchdog_run_enable;
  logic          watchdog_fired_flag;
  logic [7:0]    watchdog_timeout_seconds;
  logic [7:0]    lvl_q;
  logic          edges_armed;
  logic [TW-1:0] tick_cnt;

  // ==========================================================================
  // Address decode
  wire [7:0] wd       = reg_req.wdata;
  wire       wr_pol   = reg_req.wr && reg_req.addr == OFS_PIN_POLARITY_INVERT;
  wire       wr_mask  = reg_req.wr && reg_req.addr == OFS_PIN_INTERRUPT_MASK;
  wire       wr_stat  = reg_req.wr && reg_req.addr == OFS_PIN_INTERRUPT_STATUS;
  wire       wr_func  = reg_req.wr && reg_req.addr == OFS_PIN_FUNCTION_SELECT;
  wire       wr_route = reg_req.wr &&
                        reg_req.addr == OFS_PIN_INTERRUPT_ROUTING;
  wire       wr_ctrl  = reg_req.wr && reg_req.addr == OFS_WATCHDOG_CONTROL;
  wire       wr_tmo   = reg_req.wr && reg_req.addr == OFS_WATCHDOG_TIMEOUT;

  // ==========================================================================
  // Pin levels and edge flags
  wire [7:0] logical = pin_levels ^ pin_polarity_invert; // [RULE_02][RULE_22]
  // Synchronisers start low, so idle-high pins would flag falsely after
  // reset; edges seen during platform reset are not recorded either
  wire [7:0] edge_rise = logical & ~lvl_q & {8{edges_armed}}; // [RULE_04]
  wire [7:0] stat_clr  = wr_stat ? wd : RST_BYTE;           // [RULE_05]
  // A new edge wins over a clear in the same cycle
  wire [7:0] next_edge_flags = edge_rise | (pin_edge_flags & ~stat_clr);

  // ==========================================================================
  // Watchdog
  wire tick = tick_cnt == TW'(TICK_CYCLES_P - 1);           // [RULE_19]

  wire       next_run      = plt_reset ? 1'b0 :
                             wr_ctrl ? wd[RUN_BIT] : watchdog_run_enable;  // [RULE_16]
  wire [7:0] next_timeout;
  assign next_timeout = plt_reset ? RST_BYTE :
                        wr_tmo ? wd :                                  // [RULE_20]
                        (watchdog_run_enable && tick &&
                         watchdog_timeout_seconds != RST_BYTE) ?
                        watchdog_timeout_seconds - 8'h01 :             // [RULE_19]
                        watchdog_timeout_seconds;
  wire       next_reset_en = plt_reset ? 1'b0 :
                             wr_ctrl ? wd[RESET_EN_BIT] : wdg_reset_en;
  // Firing is judged on the new state, so a clear never hides a fresh fire
  wire       next_fire  = next_run && next_timeout == RST_BYTE;     // [RULE_18]
  wire       wdg_clear  = plt_reset || wr_tmo ||
                          (wr_ctrl && !wd[RUN_BIT]);                // [RULE_17]
  wire       next_fired = next_fire ||
                          (watchdog_fired_flag && !wdg_clear);      // [RULE_17] [RULE_23]

  // ==========================================================================
  // Interrupt requests onto serial IRQ slots
  wire        pin_irq      = |(pin_edge_flags & pin_interrupt_mask);  // [RULE_24] [RULE_03]
  wire [15:0] pin_onehot   = 16'h0001 << agw_irq_line(pin_line_select); // [RULE_13]
  wire [15:0] wdg_onehot   = 16'h0001 << agw_irq_line(wdg_line_select); // [RULE_14]
  wire [15:0] pin_slot     = pin_irq_gate ? pin_onehot : 16'h0000;
  wire [15:0] wdg_slot     = wdg_irq_gate ? wdg_onehot : 16'h0000;
  wire [15:0] next_irq_req = (pin_irq ? pin_slot : 16'h0000) |        // [RULE_24]
                             (watchdog_fired_flag ? wdg_slot : 16'h0000);  // [RULE_25]
  wire [15:0] next_slot_en = pin_slot | wdg_slot;

  // ==========================================================================
  // Pin drive and pass-through
  wire [7:0] alt_drive = pin_function_select & FN_DRIVE_MASK;
  wire [7:0] low_true  = ~logical;
  logic [7:0] alt_val;

  always_comb begin
    alt_val              = RST_BYTE;
    alt_val[FN_COMPARE3] = compare_output_three;                     // [RULE_06]
    alt_val[FN_COMPARE4] = compare_output_four;                      // [RULE_06]
    alt_val[FN_WDG_TRIG] = ~(watchdog_fired_flag ^
                             pin_polarity_invert[FN_WDG_TRIG]);      // [RULE_07]
  end

  // Input-only functions drop the GPIO driver; output functions take the pin
  wire [7:0] next_oe_b = ~((gpio_drive_en & ~pin_function_select) |
                           alt_drive);                               // [RULE_06]
  wire [7:0] next_pin_out = (gpio_drive_val & ~pin_function_select) |
                            (alt_val & alt_drive);                   // [RULE_07]
  wire [4:0] next_alt;
  assign next_alt = {pin_function_select[FN_CAPTURE3] & logical[FN_CAPTURE3],
                     pin_function_select[FN_CAPTURE4] & logical[FN_CAPTURE4],
                     ~(pin_function_select[FN_WAKE] & low_true[FN_WAKE]),
                     ~(pin_function_select[FN_WDISABLE] &
                       low_true[FN_WDISABLE]),
                     ~(pin_function_select[FN_SLEEP] & low_true[FN_SLEEP])};
                                             // [RULE_06] [RULE_08] [RULE_09] [RULE_10]

  // ==========================================================================
  // Read mux
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = RST_BYTE;
    unique case (reg_req.addr)
      OFS_PIN_INPUT_READBACK:    rd_mux = logical;                   // [RULE_01]
      OFS_PIN_INTERRUPT_MASK:    rd_mux = pin_interrupt_mask;
      OFS_PIN_INTERRUPT_STATUS:  rd_mux = pin_edge_flags;            // [RULE_05]
      OFS_PIN_FUNCTION_SELECT:   rd_mux = pin_function_select;
      OFS_PIN_INTERRUPT_ROUTING: rd_mux = {pin_irq_gate, pin_line_select,
                                           4'h0};
      OFS_WATCHDOG_CONTROL:      rd_mux = {wdg_irq_gate, wdg_line_select,
                                           1'b0, wdg_reset_en,
                                           watchdog_run_enable,
                                           watchdog_fired_flag};     // [RULE_14]
      OFS_WATCHDOG_TIMEOUT:      rd_mux = watchdog_timeout_seconds;
      OFS_PIN_POLARITY_INVERT:   rd_mux = pin_polarity_invert;
      default:                   rd_mux = RST_BYTE;
    endcase
  end

  // ==========================================================================
  // Power-on and conditional registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_function_select <= RST_BYTE;
      pin_polarity_invert <= RST_BYTE;
    end else if (ce) begin
      if (mode_reset) begin                                          // [RULE_11]
        pin_function_select <= RST_BYTE;
        pin_polarity_invert <= RST_BYTE;
      end else begin
        if (wr_func) pin_function_select <= wd;
        if (wr_pol) pin_polarity_invert <= wd;
      end
    end
  end

  // Platform-reset registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_interrupt_mask <= RST_BYTE;
      pin_irq_gate       <= 1'b0;
      pin_line_select    <= RST_SEL;
      wdg_irq_gate       <= 1'b0;
      wdg_line_select    <= RST_SEL;
    end else if (ce) begin
      if (plt_reset) begin                                           // [RULE_12]
        pin_interrupt_mask <= RST_BYTE;
        pin_irq_gate       <= 1'b0;
        pin_line_select    <= RST_SEL;
        wdg_irq_gate       <= 1'b0;
        wdg_line_select    <= RST_SEL;
      end else begin
        if (wr_mask) pin_interrupt_mask <= wd;                       // [RULE_03]
        if (wr_route) begin                                          // [RULE_13]
          pin_irq_gate    <= wd[GATE_BIT];
          pin_line_select <= wd[SEL_LSB +: 3];
        end
        if (wr_ctrl) begin                                           // [RULE_14]
          wdg_irq_gate    <= wd[GATE_BIT];
          wdg_line_select <= wd[SEL_LSB +: 3];
        end
      end
    end
  end

  // Watchdog, edge flags, tick and outputs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_run_enable      <= 1'b0;
      watchdog_timeout_seconds <= RST_BYTE;
      wdg_reset_en             <= 1'b0;
      watchdog_fired_flag      <= 1'b0;
      pin_edge_flags           <= RST_BYTE;
      lvl_q                    <= RST_BYTE;
      edges_armed              <= 1'b0;
      tick_cnt                 <= '0;
      board_reset_req          <= 1'b0;
      irq_req                  <= 16'h0000;
      irq_slot_en              <= 16'h0000;
      pin_out                  <= RST_BYTE;
      pin_oe_b                 <= RST_OE_B;
      alt_out                  <= RST_ALT;
      reg_rdata                <= RST_BYTE;
    end else if (ce) begin
      watchdog_run_enable      <= next_run;
      watchdog_timeout_seconds <= next_timeout;
      wdg_reset_en             <= next_reset_en;
      watchdog_fired_flag      <= next_fired;
      pin_edge_flags           <= next_edge_flags;
      lvl_q                    <= logical;
      edges_armed              <= ~plt_reset;
      tick_cnt                 <= tick ? '0 : tick_cnt + 1'b1;
      board_reset_req          <= next_fired & next_reset_en;        // [RULE_15]
      irq_req                  <= next_irq_req;
      irq_slot_en              <= next_slot_en;
      pin_out                  <= next_pin_out;
      pin_oe_b                 <= next_oe_b;
      alt_out                  <= next_alt;
      if (reg_req.rd) reg_rdata <= rd_mux;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_READBACK: assert property ( // [RULE_01]
    ce && reg_req.rd && reg_req.addr == OFS_PIN_INPUT_READBACK |=>
      reg_rdata == ($past(pin_levels) ^ $past(pin_polarity_invert)))
    else $error("readback differs from pin levels");
  AST_EDGE_SETS: assert property ( // [RULE_04]
    ce && edge_rise != RST_BYTE |=>
      (pin_edge_flags & $past(edge_rise)) == $past(edge_rise))
    else $error("edge did not set its flag");
  AST_W1C: assert property ( // [RULE_05]
    ce && wr_stat && edge_rise == RST_BYTE |=>
      pin_edge_flags == ($past(pin_edge_flags) & ~$past(wd)))
    else $error("status write did not clear exactly");
  AST_MASK_PLT: assert property ( // [RULE_12]
    ce && plt_reset |=> pin_interrupt_mask == RST_BYTE && !pin_irq_gate)
    else $error("mask survived platform reset");
  AST_MODE_KEEP: assert property ( // [RULE_11]
    ce && plt_reset && aux_power_keep_alive && !wr_func |=>
      $stable(pin_function_select))
    else $error("function select lost with keep-alive set");
  AST_WDG_FIRE: assert property ( // [RULE_18]
    ce && watchdog_run_enable && watchdog_timeout_seconds == RST_BYTE &&
    !reg_req.wr && !plt_reset |=> watchdog_fired_flag)
    else $error("watchdog did not fire at zero");
  AST_WDG_RELOAD: assert property ( // [RULE_20]
    ce && wr_tmo && !plt_reset |=> watchdog_timeout_seconds == $past(wd))
    else $error("timeout write did not reload");
  AST_TICK_DOWN: assert property ( // [RULE_19]
    ce && tick && watchdog_run_enable && !reg_req.wr && !plt_reset &&
    watchdog_timeout_seconds != RST_BYTE |=>
      watchdog_timeout_seconds == 8'($past(watchdog_timeout_seconds) - 8'h01))
    else $error("countdown did not step on tick");
  AST_BOARD_RESET: assert property ( // [RULE_15]
    ce && wr_ctrl && !wd[RESET_EN_BIT] |=> !board_reset_req)
    else $error("board reset without enabled firing");
  AST_PIN_IRQ: assert property ( // [RULE_24]
    ce && pin_irq && pin_irq_gate |=>
      irq_req[agw_irq_line($past(pin_line_select))])
    else $error("pin interrupt missing on its line");
  AST_WDG_DISABLE: assert property ( // [RULE_17]
    ce && wr_ctrl && !wd[RUN_BIT] |=> !watchdog_fired_flag[*2])
    else $error("fired flag kept after disable");

  COV_FIRE:   cover property (ce && !watchdog_fired_flag ##1 watchdog_fired_flag);
  COV_EDGE:   cover property (ce && edge_rise != RST_BYTE ##1 wr_stat);
  COV_PINIRQ: cover property (pin_irq && pin_irq_gate ##1 irq_req != 16'h0000);

endmodule : agw_top
`default_nettype wire

// ---- tb/agw_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Host side: byte register cycles, request held over exactly one taking edge
module agw_host_model (
  // Clock
  input  wire logic                  ref_clk,
  // Register port
  output var agw_pkg::agw_reg_req_t  reg_req,
  input  wire logic [7:0]            reg_rdata
);
  import agw_pkg::*;
  initial reg_req = '0;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    reg_req <= '0;
    @(posedge ref_clk);
    #1 d = reg_rdata;
  endtask : rd
endmodule : agw_host_model
`default_nettype wire

// ---- tb/agw_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module agw_top_tb;
  import agw_pkg::*;
  localparam int unsigned TICKS = 20;
  localparam int LINE_OF [8] = '{3, 4, 5, 10, 6, 7, 9, 11};
  logic ref_clk, rst_b, plt_rst_b, keep;
  logic [7:0] pin_in, rdata, pin_out, pin_oe_b;
  logic [15:0] irq_req, irq_slot_en;
  logic board_reset_req;
  logic [1:0] cmp;
  agw_reg_req_t reg_req;
  agw_alt_t alt_out;
  int fails, samples_checked;
  // ==========================================================================
  // Design and host
  agw_top #(.TICK_CYCLES_P(TICKS)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .ce(1'b1), .plt_rst_b(plt_rst_b), .aux_power_keep_alive(keep),
    .reg_req(reg_req), .reg_rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_b(pin_oe_b), .gpio_drive_en(8'h00), .gpio_drive_val(8'h00),
    .compare_output_three(cmp[1]), .compare_output_four(cmp[0]),
    .alt_out(alt_out), .board_reset_req(board_reset_req),
    .irq_req(irq_req), .irq_slot_en(irq_slot_en));
  agw_host_model i_host (.ref_clk(ref_clk), .reg_req(reg_req),
    .reg_rdata(rdata));
  // ==========================================================================
  // Checking helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    check({8'h00, d}, {8'h00, exp});
  endtask : rd_chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    for (int a = 1; a <= 9; a++) begin
      rd_chk(4'(a), RST_BYTE);
    end
    i_host.wr(OFS_PIN_INTERRUPT_MASK, 8'hff);
    i_host.wr(OFS_PIN_FUNCTION_SELECT, 8'h08);
    keep <= 1'b1;
    plt_rst_b <= 1'b0;
    repeat (6) @(posedge ref_clk);
    plt_rst_b <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd_chk(OFS_PIN_INTERRUPT_MASK, 8'h00);
    rd_chk(OFS_PIN_FUNCTION_SELECT, 8'h08);
  endtask : t_reset
  task automatic t_pins;
    i_host.wr(OFS_PIN_INTERRUPT_STATUS, 8'hff);
    pin_in[0] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd_chk(OFS_PIN_INPUT_READBACK, 8'h01);
    i_host.wr(OFS_PIN_INTERRUPT_STATUS, 8'h00);
    rd_chk(OFS_PIN_INTERRUPT_STATUS, 8'h01);
    i_host.wr(OFS_PIN_INTERRUPT_STATUS, 8'h01);
    rd_chk(OFS_PIN_INTERRUPT_STATUS, 8'h00);
    i_host.wr(OFS_PIN_POLARITY_INVERT, 8'h02);
    rd_chk(OFS_PIN_INPUT_READBACK, 8'h03);
    i_host.wr(OFS_PIN_INTERRUPT_STATUS, 8'hff);
    pin_in[1] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd_chk(OFS_PIN_INTERRUPT_STATUS, 8'h00);
    pin_in[1] <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd_chk(OFS_PIN_INTERRUPT_STATUS, 8'h02);
  endtask : t_pins
  task automatic t_route;
    i_host.wr(OFS_PIN_INTERRUPT_MASK, 8'h02);
    for (int s = 0; s < 8; s++) begin
      i_host.wr(OFS_PIN_INTERRUPT_ROUTING, {1'b1, 3'(s), 4'hf});
      repeat (3) @(posedge ref_clk);
      check(irq_req, 16'h1 << LINE_OF[s]);
      check(irq_slot_en, 16'h1 << LINE_OF[s]);
    end
    rd_chk(OFS_PIN_INTERRUPT_ROUTING, 8'hf0);
    i_host.wr(OFS_PIN_INTERRUPT_MASK, 8'h00);
    repeat (3) @(posedge ref_clk);
    check(irq_req, 16'h0000);
    i_host.wr(OFS_PIN_INTERRUPT_ROUTING, 8'h00);
  endtask : t_route
  task automatic t_watchdog;
    i_host.wr(OFS_WATCHDOG_TIMEOUT, 8'h02);
    i_host.wr(OFS_WATCHDOG_CONTROL, 8'hb6);
    rd_chk(OFS_WATCHDOG_CONTROL, 8'hb6);
    repeat (2 * TICKS + 5) @(posedge ref_clk);
    rd_chk(OFS_WATCHDOG_CONTROL, 8'hb7);
    check(16'(board_reset_req), 16'h0001);
    check(irq_req, 16'h0400);
    check({pin_oe_b[3], pin_out[3]}, 16'h0000);
    i_host.wr(OFS_WATCHDOG_TIMEOUT, 8'h05);
    rd_chk(OFS_WATCHDOG_CONTROL, 8'hb6);
    check({board_reset_req, pin_out[3]}, 16'h0001);
    i_host.wr(OFS_WATCHDOG_CONTROL, 8'hb4);
    i_host.wr(OFS_WATCHDOG_TIMEOUT, 8'h00);
    rd_chk(OFS_WATCHDOG_CONTROL, 8'hb4);
    i_host.wr(OFS_WATCHDOG_CONTROL, 8'h02);
    rd_chk(OFS_WATCHDOG_CONTROL, 8'h03);
    check({board_reset_req, irq_req[10]}, 16'h0000);
  endtask : t_watchdog
  task automatic t_alt;
    i_host.wr(OFS_PIN_POLARITY_INVERT, 8'h04);
    i_host.wr(OFS_PIN_FUNCTION_SELECT, 8'hf7);
    pin_in <= 8'h85;
    cmp <= 2'b10;
    repeat (8) @(posedge ref_clk);
    check({11'h0, alt_out}, 16'h0011);
    check({pin_oe_b, pin_out}, 16'hcf20);
    rd_chk(OFS_PIN_INPUT_READBACK, 8'h81);
    cmp <= 2'b01;
    pin_in <= 8'h42;
    repeat (8) @(posedge ref_clk);
    check({11'h0, alt_out}, 16'h000e);
    check({pin_oe_b, pin_out}, 16'hcf10);
  endtask : t_alt
  // ==========================================================================
  // Clock, reset, sequence and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    fails = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    plt_rst_b = 1'b1;
    keep = 1'b0;
    pin_in = 8'h00;
    cmp = 2'b00;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    t_reset();
    t_pins();
    t_route();
    t_watchdog();
    t_alt();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    give_verdict();
  end
endmodule : agw_top_tb
`default_nettype wire
